// ==== logic/i2ct_defines.vh ====
`ifndef I2CT_DEFINES_VH
`define I2CT_DEFINES_VH
// Fixed upper four bits of the target address
`define I2CT_ADDR_FIXED   4'hd
// Bits per byte on the bus
`define I2CT_BYTE_BITS    4'h8
// Register pointer value after reset
`define I2CT_PTR_RESET    8'h00
// Position of the direction bit in the address byte
`define I2CT_RW_BIT       0
`endif

// ==== logic/i2ct_sync.v ====
// Two-stage synchroniser for one input from outside the ref_clk domain
module i2ct_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Asynchronous level in, synchronised level out
  input  wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;

  // First stage read only by the second; both reset to idle-high
  always @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // i2ct_sync

// ==== logic/i2ct_target.v ====
// Summary of operation
// - Address and data travel as 8-bit bytes, most significant bit first.
// - The receiver of each byte returns an acknowledge in the ninth slot.
// - Start is data falling with clock high; stop is data rising.
// - Data changes only while the clock is low, except start and stop.
// - Own address is 1101 then select pins two, one, zero.
// - Acknowledge holds data low for the whole acknowledge clock period.
// - The data line is only ever pulled low; a pull-up gives high.
// - Any number of bytes is accepted between start and stop.
// - Write order: address with direction 0, index, data; all acknowledged.
// - Sequential write stores bytes at the index, then successive indexes.
// - Every data byte of a multi-byte write is acknowledged.
// - Read: index write, repeated start, address with direction 1, data.
// - Reads continue from successive registers while the controller acks.
// - Every register allows single or multi-byte reads and writes.
`include "i2ct_defines.vh"
module i2ct_target (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // I2C clock pin (input only, never driven)
  input  wire       scl_in,
  // I2C data pin, open drain
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  // Address select straps
  input  wire       addr_select_bit0_pin,
  input  wire       addr_select_bit1_pin,
  input  wire       addr_select_bit2_pin,
  // Register file write port
  output reg  [7:0] reg_wr_addr,
  output reg  [7:0] reg_wr_data,
  output reg        reg_wr_en,
  // Register file read port, data valid same cycle as reg_rd_addr
  output reg  [7:0] reg_rd_addr,
  input  wire [7:0] reg_rd_data,
  // Transaction active flag
  output reg        busy
);
  // One-hot states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_INDX = 6'h04;
  localparam [5:0] ST_WDAT = 6'h08;
  localparam [5:0] ST_RDAT = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  wire scl_s;
  wire sda_s;
  wire [2:0] strap_s;

  // All pins are synchronised before use
  i2ct_sync u_sync_scl (.ref_clk(ref_clk), .rst(rst), .async_in(scl_in),
                        .sync_out(scl_s));
  i2ct_sync u_sync_sda (.ref_clk(ref_clk), .rst(rst), .async_in(sda_in),
                        .sync_out(sda_s));
  genvar gi;
  wire [2:0] strap_raw;
  assign strap_raw = {addr_select_bit2_pin, addr_select_bit1_pin,
                      addr_select_bit0_pin};
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
      i2ct_sync u_sync_strap (.ref_clk(ref_clk), .rst(rst),
                              .async_in(strap_raw[gi]),
                              .sync_out(strap_s[gi]));
    end
  endgenerate

  reg        scl_q;
  reg        sda_q;
  reg  [5:0] state_q;
  reg  [3:0] bit_q;
  reg  [7:0] shift_q;
  reg  [7:0] ptr_q;
  reg        ack_slot_q;
  reg        drive_low_q;
  reg        acked_q;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  // Start and stop are data edges while the clock stays high
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire [6:0] own_addr = {`I2CT_ADDR_FIXED, strap_s};
  wire [7:0] rx_byte  = {shift_q[6:0], sda_s};

  // Only pull low; release means pull-up high
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low_q;

  // Delayed copies for edge detection
  always @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Main protocol engine. SCL is only observed, never held low
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      bit_q       <= 4'h0;
      shift_q     <= 8'h00;
      ptr_q       <= `I2CT_PTR_RESET;
      ack_slot_q  <= 1'b0;
      drive_low_q <= 1'b0;
      acked_q     <= 1'b0;
      reg_wr_addr <= 8'h00;
      reg_wr_data <= 8'h00;
      reg_wr_en   <= 1'b0;
      reg_rd_addr <= 8'h00;
      busy        <= 1'b0;
    end else begin
      reg_wr_en <= 1'b0;
      if (start_det) begin
        // Start or repeated start ends any write burst
        state_q     <= ST_ADDR;
        bit_q       <= 4'h0;
        ack_slot_q  <= 1'b0;
        acked_q     <= 1'b0;
        drive_low_q <= 1'b0;
        busy        <= 1'b1;
      end else if (stop_det) begin
        state_q     <= ST_IDLE;
        ack_slot_q  <= 1'b0;
        drive_low_q <= 1'b0;
        busy        <= 1'b0;
      end else if (scl_rise && !ack_slot_q) begin
        // Sample on rising clock, MSB first
        // While transmitting, the shifter holds outgoing bits: leave it
        if (state_q != ST_RDAT) begin
          shift_q <= rx_byte;
        end
        if (bit_q == `I2CT_BYTE_BITS - 4'h1) begin
          bit_q <= 4'h0;
          ack_slot_q <= 1'b1;
          case (state_q)
            ST_ADDR: begin
              if (shift_q[6:0] != own_addr) begin
                state_q <= ST_IDLE;
                busy    <= 1'b0;
                ack_slot_q <= 1'b0;
              end else if (rx_byte[`I2CT_RW_BIT]) begin
                state_q <= ST_RDAT;
              end else begin
                state_q <= ST_INDX;
              end
            end
            ST_INDX: begin
              ptr_q   <= rx_byte;
              state_q <= ST_WDAT;
            end
            ST_WDAT: begin
              // Store and advance; no length limit
              reg_wr_addr <= ptr_q;
              reg_wr_data <= rx_byte;
              reg_wr_en   <= 1'b1;
              ptr_q       <= ptr_q + 8'h01;
            end
            ST_RDAT: begin
              // Master's ack sampled in ninth slot below
              state_q <= ST_RACK;
            end
            default: begin
              state_q    <= ST_IDLE;
              ack_slot_q <= 1'b0;
            end
          endcase
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else if (scl_rise && ack_slot_q && state_q == ST_RACK) begin
        // Master ack means keep sending
        acked_q <= ~sda_s;
        if (sda_s) begin
          state_q    <= ST_IDLE;
          busy       <= 1'b0;
          ack_slot_q <= 1'b0;
        end else begin
          state_q <= ST_RDAT;
          ptr_q   <= ptr_q + 8'h01;
        end
      end else if (scl_fall) begin
        if (ack_slot_q && state_q == ST_RACK) begin
          // Last bit of the byte done: release for master ack
          drive_low_q <= 1'b0;
        end else if (ack_slot_q && state_q == ST_RDAT &&
                     (acked_q || drive_low_q)) begin
          // Ninth slot over: put out the MSB of the next byte at once,
          // so the bit stands for the whole low phase
          ack_slot_q  <= 1'b0;
          acked_q     <= 1'b0;
          bit_q       <= 4'h0;
          drive_low_q <= ~reg_rd_data[7];
          shift_q     <= {reg_rd_data[6:0], 1'b0};
        end else if (ack_slot_q && drive_low_q) begin
          // Ninth slot of a received byte over: release
          drive_low_q <= 1'b0;
          ack_slot_q  <= 1'b0;
        end else if (ack_slot_q) begin
          // Pull low across whole ninth clock period
          drive_low_q <= 1'b1;
        end else if (state_q == ST_RDAT) begin
          // Transmit next bit on falling clock
          drive_low_q <= ~shift_q[7];
          shift_q     <= {shift_q[6:0], 1'b0};
        end
      end
      // Read port follows the pointer one cycle behind, so read data
      // is settled long before the falling clock that sends it
      reg_rd_addr <= ptr_q;
    end
  end
endmodule // i2ct_target

// ==== dv/i2ct_checker.sv ====
module i2ct_checker (
  // Clock, reset and bus pins
  input wire       ref_clk,
  input wire       rst,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_n,
  // Register port and status
  input wire [7:0] reg_wr_addr,
  input wire       reg_wr_en,
  input wire [7:0] reg_rd_addr,
  input wire       busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Skip the rise cycle: the pin leads the synchronised copy
  sequence s_hold;
    ##1 $stable(sda_oe_n) [*3];
  endsequence
  // Pin behaviour and register strobes
  drive_low_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  oe_hold_a: assert property ($rose(scl_in) |-> s_hold)
    else $error("data drive moved while clock high");
  wr_pulse_a: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write strobe too long");
  wr_busy_a: assert property (reg_wr_en |-> busy)
    else $error("write outside a transaction");
  ptr_step_a: assert property (reg_wr_en |->
    ##[0:4] reg_rd_addr == reg_wr_addr + 8'h01)
    else $error("pointer did not advance");
  stop_idle_a: assert property (scl_in && $rose(sda_in) |->
    ##[1:8] !busy)
    else $error("stop did not end the transaction");
  reset_idle_a: assert property ($fell(rst) |->
    sda_oe_n && !busy && !reg_wr_en)
    else $error("not idle after reset");
  ack_busy_a: assert property ($fell(sda_oe_n) |-> ##[0:2] busy)
    else $error("pin pulled outside a transaction");
endmodule // i2ct_checker

bind i2ct_target i2ct_checker i2ct_checker_i (.ref_clk, .rst, .scl_in,
  .sda_in, .sda_out, .sda_oe_n, .reg_wr_addr, .reg_wr_en, .reg_rd_addr,
  .busy);

// ==== dv/i2ct_master.sv ====
module i2ct_master #(
  parameter int Q = 2
) (
  // Clock, wire level and own drives
  input  wire  ref_clk,
  input  wire  sda,
  output logic scl   = 1'b1,
  output logic sda_m = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Whole reference cycles, so every change lands just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Data is only pulled low or released to the pull-up; the clock is driven high and low
  task automatic put(input logic c, input logic dv);
    tick(Q);
    scl <= c;
    sda_m <= dv;
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start();
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
  endtask
  // Stop: data rises with clock high; lines then stand still
  task automatic stop();
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask
  // Data moves in the low phase, sampled mid high phase
  task automatic slot(input logic dv, output logic s);
    put(1'b0, dv);
    put(1'b1, dv);
    tick(Q);
    s = sda;
    put(1'b0, dv);
  endtask
  // Byte MSB first, then the receiver's ninth slot
  task automatic xfer(input logic [7:0] o, input logic ak,
                      output logic [7:0] i, output logic a);
    for (int k = 7; k >= 0; k--)
      slot(o[k], i[k]);
    slot(ak, a);
  endtask
endmodule // i2ct_master

// ==== dv/i2ct_target_test.sv ====
module i2ct_target_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] pins = 3'b101;
  logic [7:0] regs [256] = '{default: 8'h00};
  logic [7:0] d;
  logic       a;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  wire        scl, sda_m, sda_out, sda_oe_n, reg_wr_en, busy;
  wire  [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr;
  // Wired-AND with pull-up: low if any party pulls
  wire        sda = sda_m & (sda_oe_n | sda_out);
  // 40 MHz reference
  always #12.5 ref_clk = ~ref_clk;
  i2ct_target i2ct_target_i (.ref_clk, .rst, .scl_in(scl), .sda_in(sda),
    .sda_out, .sda_oe_n, .addr_select_bit0_pin(pins[0]),
    .addr_select_bit1_pin(pins[1]), .addr_select_bit2_pin(pins[2]),
    .reg_wr_addr, .reg_wr_data, .reg_wr_en, .reg_rd_addr,
    .reg_rd_data(regs[reg_rd_addr]), .busy);
  i2ct_master i2ct_master_i (.ref_clk, .sda, .scl, .sda_m);
  // Register file behind the port; run ceiling catches a hang
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (reg_wr_en === 1'b1)
      regs[reg_wr_addr] <= reg_wr_data;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input string s, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Low in the ninth slot means acknowledged
  task automatic wr(input logic [7:0] b, input logic ak);
    i2ct_master_i.xfer(b, 1'b1, d, a);
    check("ack", {7'h00, a}, {7'h00, ak});
  endtask
  task automatic rd(input logic [7:0] e, input logic nak);
    i2ct_master_i.xfer(8'hff, nak, d, a);
    check("read", d, e);
  endtask
  // Burst write across the pointer wrap
  task automatic t_write();
    i2ct_master_i.start();
    wr({4'hd, pins, 1'b0}, 1'b0);
    wr(8'hfe, 1'b0);
    wr(8'ha5, 1'b0);
    wr(8'h3c, 1'b0);
    wr(8'h81, 1'b0);
    i2ct_master_i.stop();
    i2ct_master_i.tick(8);
    check("busy", {7'h00, busy}, 8'h00);
    check("reg fe", regs[8'hfe], 8'ha5);
    check("reg ff", regs[8'hff], 8'h3c);
    check("reg 00", regs[8'h00], 8'h81);
    $display("write test done");
  endtask
  // Index write, repeated start, burst read ended by not-ack
  task automatic t_read();
    i2ct_master_i.start();
    wr({4'hd, pins, 1'b0}, 1'b0);
    wr(8'hfe, 1'b0);
    i2ct_master_i.start();
    wr({4'hd, pins, 1'b1}, 1'b0);
    check("busy", {7'h00, busy}, 8'h01);
    rd(8'ha5, 1'b0);
    rd(8'h3c, 1'b0);
    rd(8'h81, 1'b1);
    i2ct_master_i.stop();
    $display("read test done");
  endtask
  // Strap order and foreign addresses, then a single-byte write
  task automatic t_foreign();
    @(posedge ref_clk) pins <= 3'b110;
    i2ct_master_i.tick(8);
    i2ct_master_i.start();
    wr(8'hd6, 1'b1);
    wr(8'h10, 1'b1);
    i2ct_master_i.start();
    wr(8'h9c, 1'b1);
    i2ct_master_i.start();
    wr(8'hdc, 1'b0);
    wr(8'h10, 1'b0);
    wr(8'h5a, 1'b0);
    i2ct_master_i.stop();
    check("reg 10", regs[8'h10], 8'h5a);
    $display("address test done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    i2ct_master_i.tick(4);
    t_write();
    t_read();
    t_foreign();
    results();
  end
endmodule // i2ct_target_test
